/* File: rtl/csir_pkg.sv */
// Package for the processor status and interrupt register bank.
// Assumes a single core clock; offsets are word indexes on the plain port.
package csir_pkg;
  localparam int          CSIR_ADDR_W        = 4;
  localparam logic [3:0]  CSIR_OFS_STATUS    = 4'h0;
  localparam logic [3:0]  CSIR_OFS_IRQ_EN    = 4'h1;
  localparam logic [3:0]  CSIR_OFS_IRQ_PEND  = 4'h2;
  localparam logic [3:0]  CSIR_OFS_PIN_FLAG  = 4'h3;
  localparam logic [3:0]  CSIR_OFS_ALU_CTRL  = 4'h4;
  localparam logic [3:0]  CSIR_OFS_ALU_A     = 4'h5;
  localparam logic [3:0]  CSIR_OFS_ALU_B     = 4'h6;
  localparam logic [3:0]  CSIR_OFS_ALU_RES   = 4'h7;
  localparam logic [3:0]  CSIR_OFS_IRQ_TAKEN = 4'h8;
  // Status word bit positions
  localparam int          CSIR_PSW_CARRY     = 0;
  localparam int          CSIR_PSW_OVF       = 1;
  localparam int          CSIR_PSW_ZERO      = 2;
  localparam int          CSIR_PSW_NEG       = 3;
  localparam int          CSIR_PSW_UNDERFLOW = 4;
  localparam int          CSIR_PSW_STKY_OVF  = 5;
  localparam int          CSIR_PSW_STKY_UND  = 6;
  localparam int          CSIR_PSW_SAT_MODE  = 7;
  localparam int          CSIR_PSW_REPEAT    = 8;
  localparam int          CSIR_PSW_FREEZE    = 10;
  localparam int          CSIR_PSW_CACHE_EN  = 11;
  localparam int          CSIR_PSW_INVAL     = 12;
  localparam int          CSIR_PSW_IRQ_GATE  = 13;
  // Writable status bits 0-7,10-13; 8 is hardware, 9 and 14-31 read 0
  localparam logic [31:0] CSIR_PSW_WMASK     = 32'h0000_3CFF;
  localparam logic [31:0] CSIR_PSW_RESET     = 32'h0000_0000;
  // Interrupt sources: ext 0-3, serial tx/rx 0/1, timer 0/1, DMA
  localparam int          CSIR_NUM_IRQ       = 11;
  localparam int          CSIR_DMA_EN_LSB    = 16;
  localparam logic [31:0] CSIR_EN_WMASK      = 32'h07FF_07FF;
  localparam logic [31:0] CSIR_EN_RESET      = 32'h0000_0000;
  localparam logic [31:0] CSIR_PEND_RESET    = 32'h0000_0000;
  // Pin flag register bits
  localparam int          CSIR_PF_DIR0       = 1;
  localparam int          CSIR_PF_DRV0       = 2;
  localparam int          CSIR_PF_SMP0       = 3;
  localparam int          CSIR_PF_DIR1       = 5;
  localparam int          CSIR_PF_DRV1       = 6;
  localparam int          CSIR_PF_SMP1       = 7;
  localparam logic [31:0] CSIR_PF_RESET      = 32'h0000_0000;
  // Saturation limits
  localparam logic [31:0] CSIR_SAT_POS       = 32'h7FFF_FFFF;
  localparam logic [31:0] CSIR_SAT_NEG       = 32'h8000_0000;
  // ALU control: bit 0 subtract, bit 1 integer (else float status only)
  localparam int          CSIR_ALU_SUB       = 0;
  localparam int          CSIR_ALU_INT       = 1;
  typedef enum logic [1:0] {
    CSIR_OP_IDLE = 2'b00,
    CSIR_OP_ADD  = 2'b01,
    CSIR_OP_SUB  = 2'b10
  } csir_op_type;
endpackage

/* File: rtl/csir_pin_sync.sv */
// Three-stage synchroniser for one pin input with agreement filter.
// Assumes pin is asynchronous to clk_in.
`timescale 1ns/1ps
`default_nettype none
module csir_pin_sync
  import csir_pkg::*;
(
  input  wire logic clk_in,     // Core clock
  input  wire logic reset_n_in, // Async reset, active low
  input  wire logic pin_in,     // Raw pin level
  output logic      level_out   // Filtered level
);
  logic meta_r;
  logic s2_r;
  logic s3_r;
  logic level_r;

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      meta_r  <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_r <= 1'b0;
    end
    else
    begin
      meta_r <= pin_in;
      s2_r   <= meta_r;
      s3_r   <= s2_r;
      // Change counts only when stages two and three agree
      if (s2_r == s3_r)
      begin
        level_r <= s3_r;
      end
    end
  end

  assign level_out = level_r;
endmodule
`default_nettype wire

/* File: rtl/csir_regs.sv */
// Processor status, interrupt enable/pending and flag-pin registers.
// Assumes core datapath and peripherals on clk_in; flag pins asynchronous.
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module csir_regs
  import csir_pkg::*;
#(
  parameter int NUM_IRQ = CSIR_NUM_IRQ
)
(
  input  wire logic                   clk_in,           // Core clock, 125 MHz
  input  wire logic                   reset_n_in,       // Async reset, active low
  input  wire logic [CSIR_ADDR_W-1:0] addr_in,          // Register word index
  input  wire logic [31:0]            wdata_in,         // Write data
  input  wire logic                   wr_in,            // Write strobe
  input  wire logic                   rd_in,            // Read strobe
  output logic      [31:0]            rdata_out,        // Read data, next cycle
  input  wire logic [NUM_IRQ-1:0]     irq_event_in,     // Source event pulses
  input  wire logic                   repeat_active_in, // Repeat drives PC
  input  wire logic                   irq_ack_in,       // CPU entered service
  output logic                        cpu_irq_out,      // CPU interrupt request
  output logic      [NUM_IRQ-1:0]     dma_irq_out,      // DMA sync requests
  output logic                        cache_enable_out, // Cache may be used
  output logic                        cache_update_out, // Cache may change
  output logic                        cache_inval_out,  // Invalidate all, pulse
  input  wire logic                   flag_pin_0_in,    // Pin 0 level
  output logic                        flag_pin_0_out,   // Pin 0 drive value
  output logic                        flag_pin_0_oe_n_out, // Pin 0 enable, low drives
  input  wire logic                   flag_pin_1_in,    // Pin 1 level
  output logic                        flag_pin_1_out,   // Pin 1 drive value
  output logic                        flag_pin_1_oe_n_out  // Pin 1 enable, low drives
);
  logic [31:0]        status_r;
  logic [31:0]        irq_en_r;
  logic [NUM_IRQ-1:0] irq_pend_r;
  logic [NUM_IRQ-1:0] irq_pend_nxt;
  logic [31:0]        pin_ctrl_r;
  logic [31:0]        rdata_r;
  logic [1:0]         alu_ctrl_r;
  logic [31:0]        alu_a_r;
  logic [31:0]        alu_b_r;
  logic [31:0]        alu_res_r;
  logic [NUM_IRQ-1:0] taken_r;
  logic               cache_inval_r;
  logic               pin0_level;
  logic               pin1_level;
  logic               wr_status;
  logic               wr_pend;
  logic               alu_go;
  csir_op_type        op;
  logic [32:0]        sum;
  logic [31:0]        raw;
  logic [31:0]        result;
  logic               ovf;
  logic               carry;
  logic [NUM_IRQ-1:0] cpu_ready;

  assign wr_status = wr_in && (addr_in == CSIR_OFS_STATUS);
  assign wr_pend   = wr_in && (addr_in == CSIR_OFS_IRQ_PEND);
  assign alu_go    = wr_in && (addr_in == CSIR_OFS_ALU_B);

  // Integer datapath stand-in: a write to operand B launches one op
  always_comb
  begin
    op = CSIR_OP_IDLE;
    if (alu_go)
    begin
      op = alu_ctrl_r[CSIR_ALU_SUB] ? CSIR_OP_SUB : CSIR_OP_ADD;
    end
  end

  always_comb
  begin
    if (op == CSIR_OP_SUB)
    begin
      sum = {1'b0, alu_a_r} - {1'b0, wdata_in};
      ovf = (alu_a_r[31] != wdata_in[31]) && (sum[31] != alu_a_r[31]);
    end
    else
    begin
      sum = {1'b0, alu_a_r} + {1'b0, wdata_in};
      ovf = (alu_a_r[31] == wdata_in[31]) && (sum[31] != alu_a_r[31]);
    end
    carry = sum[32];
    raw   = sum[31:0];
    result = raw;
    if (ovf && status_r[CSIR_PSW_SAT_MODE] && alu_ctrl_r[CSIR_ALU_INT] && !alu_a_r[31])
    begin
      result = CSIR_SAT_POS;
    end
    if (ovf && status_r[CSIR_PSW_SAT_MODE] && alu_ctrl_r[CSIR_ALU_INT] && alu_a_r[31])
    begin
      result = CSIR_SAT_NEG;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      alu_ctrl_r <= 2'h0;
      alu_a_r    <= 32'h0000_0000;
      alu_b_r    <= 32'h0000_0000;
      alu_res_r  <= 32'h0000_0000;
    end
    else
    begin
      if (wr_in && (addr_in == CSIR_OFS_ALU_CTRL))
      begin
        alu_ctrl_r <= wdata_in[1:0];
      end
      if (wr_in && (addr_in == CSIR_OFS_ALU_A))
      begin
        alu_a_r <= wdata_in;
      end
      if (alu_go)
      begin
        alu_b_r   <= wdata_in;
        alu_res_r <= result;
      end
    end
  end

  // Status word: software load is masked by CSIR_PSW_WMASK; datapath updates flags
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      status_r <= CSIR_PSW_RESET;
    end
    else
    begin
      if (wr_status)
      begin
        status_r <= wdata_in & CSIR_PSW_WMASK;
      end
      else if (alu_go)
      begin
        status_r[CSIR_PSW_CARRY] <= carry;
        status_r[CSIR_PSW_OVF]   <= ovf;
        status_r[CSIR_PSW_ZERO]  <= (result == 32'h0000_0000);
        status_r[CSIR_PSW_NEG]   <= result[31];
        // carry and overflow same with or without saturation; zero and sign from saturated result
        status_r[CSIR_PSW_STKY_OVF] <= status_r[CSIR_PSW_STKY_OVF] | ovf;
        if (!alu_ctrl_r[CSIR_ALU_INT])
        begin
          status_r[CSIR_PSW_UNDERFLOW] <= 1'b0;
        end
      end
      status_r[CSIR_PSW_INVAL] <= 1'b0;
      status_r[CSIR_PSW_REPEAT] <= repeat_active_in;
    end
  end

  // clear honoured when unfrozen or disabled
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cache_inval_r <= 1'b0;
    end
    else
    begin
      cache_inval_r <= wr_status && wdata_in[CSIR_PSW_INVAL]
                       && (!status_r[CSIR_PSW_FREEZE] || !status_r[CSIR_PSW_CACHE_EN]);
    end
  end

  assign cache_inval_out  = cache_inval_r;
  assign cache_enable_out = status_r[CSIR_PSW_CACHE_EN];
  // frozen cache keeps contents and LRU
  assign cache_update_out = status_r[CSIR_PSW_CACHE_EN] && !status_r[CSIR_PSW_FREEZE];

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      irq_en_r <= CSIR_EN_RESET;
    end
    else if (wr_in && (addr_in == CSIR_OFS_IRQ_EN))
    begin
      irq_en_r <= wdata_in & CSIR_EN_WMASK;
    end
  end

  // events and software ones set; event beats clear
  always_comb
  begin
    irq_pend_nxt = irq_pend_r;
    if (wr_pend)
    begin
      irq_pend_nxt = wdata_in[NUM_IRQ-1:0];
    end
    irq_pend_nxt = (irq_pend_nxt & ~taken_r) | irq_event_in;
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      irq_pend_r <= CSIR_PEND_RESET[NUM_IRQ-1:0];
    end
    else
    begin
      irq_pend_r <= irq_pend_nxt;
    end
  end

  // Highest-priority ready source, lowest bit first
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IRQ; gi++)
    begin : g_src
      // CPU: pending, CPU enable and global enable; DMA: pending and DMA enable only
      assign cpu_ready[gi] = irq_pend_r[gi] && irq_en_r[gi] && status_r[CSIR_PSW_IRQ_GATE];
      assign dma_irq_out[gi] = irq_pend_r[gi] && irq_en_r[CSIR_DMA_EN_LSB + gi];
    end
  endgenerate

  assign cpu_irq_out = |cpu_ready;

  // Acknowledge clears the serviced flag next cycle
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      taken_r <= '0;
    end
    else
    begin
      taken_r <= '0;
      if (irq_ack_in)
      begin
        taken_r <= cpu_ready & ~(cpu_ready - NUM_IRQ'(1));
      end
    end
  end

  csir_pin_sync u_sync0
  (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .pin_in     (flag_pin_0_in),
    .level_out  (pin0_level)
  );

  csir_pin_sync u_sync1
  (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .pin_in     (flag_pin_1_in),
    .level_out  (pin1_level)
  );

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pin_ctrl_r <= CSIR_PF_RESET;
    end
    else if (wr_in && (addr_in == CSIR_OFS_PIN_FLAG))
    begin
      pin_ctrl_r[CSIR_PF_DIR0] <= wdata_in[CSIR_PF_DIR0];
      pin_ctrl_r[CSIR_PF_DRV0] <= wdata_in[CSIR_PF_DRV0];
      pin_ctrl_r[CSIR_PF_DIR1] <= wdata_in[CSIR_PF_DIR1];
      pin_ctrl_r[CSIR_PF_DRV1] <= wdata_in[CSIR_PF_DRV1];
    end
  end

  assign flag_pin_0_out      = pin_ctrl_r[CSIR_PF_DRV0];
  assign flag_pin_0_oe_n_out = !pin_ctrl_r[CSIR_PF_DIR0];
  assign flag_pin_1_out      = pin_ctrl_r[CSIR_PF_DRV1];
  assign flag_pin_1_oe_n_out = !pin_ctrl_r[CSIR_PF_DIR1];

  // Read mux; unmapped indexes read zero
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      rdata_r <= 32'h0000_0000;
      if (rd_in)
      begin
        if (addr_in == CSIR_OFS_STATUS)
        begin
          rdata_r <= status_r;
        end
        else if (addr_in == CSIR_OFS_IRQ_EN)
        begin
          rdata_r <= irq_en_r;
        end
        else if (addr_in == CSIR_OFS_IRQ_PEND)
        begin
          // bits above DMA flag read zero
          rdata_r <= {{(32-NUM_IRQ){1'b0}}, irq_pend_r};
        end
        else if (addr_in == CSIR_OFS_PIN_FLAG)
        begin
          rdata_r <= {24'h000000, pin1_level, pin_ctrl_r[CSIR_PF_DRV1],
                      pin_ctrl_r[CSIR_PF_DIR1], 1'b0, pin0_level,
                      pin_ctrl_r[CSIR_PF_DRV0], pin_ctrl_r[CSIR_PF_DIR0], 1'b0};
        end
        else if (addr_in == CSIR_OFS_ALU_CTRL)
        begin
          rdata_r <= {30'h0000_0000, alu_ctrl_r};
        end
        else if (addr_in == CSIR_OFS_ALU_A)
        begin
          rdata_r <= alu_a_r;
        end
        else if (addr_in == CSIR_OFS_ALU_B)
        begin
          rdata_r <= alu_b_r;
        end
        else if (addr_in == CSIR_OFS_ALU_RES)
        begin
          rdata_r <= alu_res_r;
        end
        else if (addr_in == CSIR_OFS_IRQ_TAKEN)
        begin
          rdata_r <= {{(32-NUM_IRQ){1'b0}}, cpu_ready};
        end
      end
    end
  end

  assign rdata_out = rdata_r;
endmodule
`default_nettype wire

/* File: test/csir_core_model.sv */
// Model of the core side: interrupt sources, repeat line, acknowledge, flag pins.
// Assumes the bench calls its tasks; pin levels resolve from the block's enables.
`timescale 1ns/1ps
`default_nettype none
module csir_core_model
  import csir_pkg::*;
(
  input  wire logic                    clk_in,        // Core clock
  input  wire logic                    pin_0_oe_n_in, // Block drives pin 0 when low
  input  wire logic                    pin_0_drv_in,  // Block drive value, pin 0
  input  wire logic                    pin_1_oe_n_in, // Block drives pin 1 when low
  input  wire logic                    pin_1_drv_in,  // Block drive value, pin 1
  output var  logic [CSIR_NUM_IRQ-1:0] irq_event_out, // Source event pulses
  output var  logic                    irq_ack_out,   // Service entry pulse
  output var  logic                    repeat_out,    // Repeat drives PC
  output logic                         pin_0_out,     // Resolved pin 0 level
  output logic                         pin_1_out      // Resolved pin 1 level
);
  logic ext_0_r;
  logic ext_1_r;
  initial
  begin
    irq_event_out = '0;
    irq_ack_out = 1'b0;
    repeat_out = 1'b0;
    ext_0_r = 1'b0;
    ext_1_r = 1'b0;
  end
  // Outside driver wins only while the block lets go of the pin
  assign pin_0_out = pin_0_oe_n_in ? ext_0_r : pin_0_drv_in;
  assign pin_1_out = pin_1_oe_n_in ? ext_1_r : pin_1_drv_in;
  task automatic fire(input int idx);
    @(posedge clk_in);
    irq_event_out[idx] <= 1'b1;
    @(posedge clk_in);
    irq_event_out <= '0;
  endtask
  task automatic ack();
    @(posedge clk_in);
    irq_ack_out <= 1'b1;
    @(posedge clk_in);
    irq_ack_out <= 1'b0;
  endtask
  task automatic set_lines(input logic rep, input logic e0, input logic e1);
    @(posedge clk_in);
    repeat_out <= rep;
    ext_0_r <= e0;
    ext_1_r <= e1;
  endtask
endmodule
`default_nettype wire

/* File: test/csir_regs_sva.sv */
// Checker for the status and interrupt register bank, on its ports only.
// Assumes one clock domain; bound into every instance of the register bank.
`timescale 1ns/1ps
`default_nettype none
module csir_regs_sva
  import csir_pkg::*;
#(
  parameter int NUM_IRQ = CSIR_NUM_IRQ
)
(
  input wire logic                   clk_in,              // Core clock
  input wire logic                   reset_n_in,          // Async reset
  input wire logic [CSIR_ADDR_W-1:0] addr_in,             // Word index
  input wire logic [31:0]            wdata_in,            // Write data
  input wire logic                   wr_in,               // Write strobe
  input wire logic                   rd_in,               // Read strobe
  input wire logic [31:0]            rdata_out,           // Read data
  input wire logic                   cpu_irq_out,         // CPU request
  input wire logic [NUM_IRQ-1:0]     dma_irq_out,         // DMA requests
  input wire logic                   cache_enable_out,    // Cache enabled
  input wire logic                   cache_update_out,    // Cache may change
  input wire logic                   cache_inval_out,     // Invalidate pulse
  input wire logic                   flag_pin_0_out,      // Pin 0 drive
  input wire logic                   flag_pin_0_oe_n_out, // Pin 0 enable
  input wire logic                   flag_pin_1_out,      // Pin 1 drive
  input wire logic                   flag_pin_1_oe_n_out  // Pin 1 enable
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  logic st_wr;
  assign st_wr = wr_in && (addr_in == CSIR_OFS_STATUS);
  a_rdata_idle_zero: assert property (!$past(rd_in) |-> rdata_out == 32'h0000_0000)
    else $error("read data not zero outside read answer");
  a_inval_one_pulse: assert property (cache_inval_out |=> !cache_inval_out)
    else $error("invalidate pulse longer than one cycle");
  a_inval_has_cause: assert property (cache_inval_out |->
    $past(st_wr && wdata_in[CSIR_PSW_INVAL] && !(cache_enable_out && !cache_update_out)))
    else $error("invalidate without allowed clear request");
  a_inval_when_ok: assert property (st_wr && wdata_in[CSIR_PSW_INVAL]
    && (cache_update_out || !cache_enable_out) |=> cache_inval_out)
    else $error("allowed clear request gave no invalidate");
  a_update_needs_en: assert property (cache_update_out |-> cache_enable_out)
    else $error("cache update while cache disabled");
  a_freeze_blocks_upd: assert property (st_wr && wdata_in[CSIR_PSW_FREEZE]
    |=> !cache_update_out)
    else $error("cache update while frozen");
  a_enable_follows: assert property (st_wr |=>
    cache_enable_out == $past(wdata_in[CSIR_PSW_CACHE_EN]))
    else $error("cache enable does not follow write");
  a_gate_off_quiet: assert property (st_wr && !wdata_in[CSIR_PSW_IRQ_GATE]
    |=> !cpu_irq_out)
    else $error("cpu request with global enable off");
  a_dma_en_off: assert property (wr_in && addr_in == CSIR_OFS_IRQ_EN
    && wdata_in[26:16] == 11'h000 |=> dma_irq_out == '0)
    else $error("dma request with all dma enables off");
  a_pin0_follows: assert property (wr_in && addr_in == CSIR_OFS_PIN_FLAG
    |=> flag_pin_0_oe_n_out == !$past(wdata_in[CSIR_PF_DIR0])
    && flag_pin_0_out == $past(wdata_in[CSIR_PF_DRV0]))
    else $error("pin 0 drive does not follow write");
  a_pin1_follows: assert property (wr_in && addr_in == CSIR_OFS_PIN_FLAG
    |=> flag_pin_1_oe_n_out == !$past(wdata_in[CSIR_PF_DIR1])
    && flag_pin_1_out == $past(wdata_in[CSIR_PF_DRV1]))
    else $error("pin 1 drive does not follow write");
  c_inval: cover property (cache_inval_out);
  c_cpu_irq: cover property (cpu_irq_out);
  c_pin_out: cover property (!flag_pin_0_oe_n_out && !flag_pin_1_oe_n_out);
endmodule
bind csir_regs csir_regs_sva #(.NUM_IRQ(NUM_IRQ)) u_sva (.clk_in(clk_in), .reset_n_in(reset_n_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .cpu_irq_out(cpu_irq_out), .dma_irq_out(dma_irq_out), .cache_enable_out(cache_enable_out),
  .cache_update_out(cache_update_out), .cache_inval_out(cache_inval_out),
  .flag_pin_0_out(flag_pin_0_out), .flag_pin_0_oe_n_out(flag_pin_0_oe_n_out),
  .flag_pin_1_out(flag_pin_1_out), .flag_pin_1_oe_n_out(flag_pin_1_oe_n_out));
`default_nettype wire

/* File: test/test_csir_regs.sv */
// Self-checking bench for the status and interrupt register bank.
// Assumes the core model in csir_core_model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module test_csir_regs
  import csir_pkg::*;
;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [31:0] wdata_in = 32'h0000_0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [31:0] rdata_out;
  logic [10:0] irq_event, dma_irq_out;
  logic irq_ack, repeat_act, cpu_irq_out, cache_enable_out, cache_update_out, cache_inval_out;
  logic pin_0, pin_1, drv_0, drv_1, oe_0_n, oe_1_n;
  logic [31:0] v;
  int fail_count = 0;
  int comparisons = 0;
  // Rows: status, alu control, operand A, expected result; B is always 1
  logic [31:0] alu_tab [4][4] = '{'{32'h80, 32'h2, 32'h7FFF_FFFF, 32'h7FFF_FFFF},
    '{32'h80, 32'h3, 32'h8000_0000, 32'h8000_0000}, '{32'h0, 32'h2, 32'h7FFF_FFFF, 32'h8000_0000},
    '{32'h80, 32'h0, 32'h7FFF_FFFF, 32'h8000_0000}};
  always #4 clk_in = ~clk_in;
  csir_regs dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .irq_event_in(irq_event), .repeat_active_in(repeat_act), .irq_ack_in(irq_ack),
    .cpu_irq_out(cpu_irq_out), .dma_irq_out(dma_irq_out), .cache_enable_out(cache_enable_out),
    .cache_update_out(cache_update_out), .cache_inval_out(cache_inval_out),
    .flag_pin_0_in(pin_0), .flag_pin_0_out(drv_0), .flag_pin_0_oe_n_out(oe_0_n),
    .flag_pin_1_in(pin_1), .flag_pin_1_out(drv_1), .flag_pin_1_oe_n_out(oe_1_n));
  csir_core_model core (.clk_in(clk_in), .pin_0_oe_n_in(oe_0_n), .pin_0_drv_in(drv_0),
    .pin_1_oe_n_in(oe_1_n), .pin_1_drv_in(drv_1), .irq_event_out(irq_event),
    .irq_ack_out(irq_ack), .repeat_out(repeat_act), .pin_0_out(pin_0), .pin_1_out(pin_1));
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      $display("Error %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  // Strobe one cycle; returns just after the edge that took it
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    rd(a, v);
    check(v, exp);
  endtask
  initial
  begin
    repeat (5000) @(posedge clk_in);
    fail_count++;
    end_of_test();
  end
  initial
  begin
    repeat (3) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd_chk(CSIR_OFS_STATUS, 32'h0000_0000);
    rd_chk(CSIR_OFS_IRQ_EN, 32'h0000_0000);
    rd_chk(CSIR_OFS_IRQ_PEND, 32'h0000_0000);
    rd_chk(CSIR_OFS_PIN_FLAG, 32'h0000_0000);
    check({oe_1_n, oe_0_n}, 32'h3);
    wr(CSIR_OFS_STATUS, 32'hFFFF_FFFF);
    check(cache_inval_out, 32'h1);
    check(cache_update_out, 32'h0);
    rd_chk(CSIR_OFS_STATUS, 32'h0000_2CFF);
    wr(CSIR_OFS_STATUS, 32'h0000_1800);
    check(cache_inval_out, 32'h0);
    wr(CSIR_OFS_STATUS, 32'h0000_1800);
    check(cache_inval_out, 32'h1);
    check(cache_update_out, 32'h1);
    check(cache_enable_out, 32'h1);
    core.set_lines(1'b1, 1'b1, 1'b0);
    repeat (2) @(posedge clk_in);
    rd_chk(CSIR_OFS_STATUS, 32'h0000_0900);
    core.set_lines(1'b0, 1'b1, 1'b0);
    wr(CSIR_OFS_IRQ_EN, 32'hFFFF_FFFF);
    rd_chk(CSIR_OFS_IRQ_EN, 32'h07FF_07FF);
    wr(CSIR_OFS_STATUS, 32'h0000_2000);
    for (int i = 0; i < CSIR_NUM_IRQ; i++)
    begin
      core.fire(i);
      #1;
      check(cpu_irq_out, 32'h1);
      check(dma_irq_out, 32'h1 << i);
      rd_chk(CSIR_OFS_IRQ_PEND, 32'h1 << i);
      wr(CSIR_OFS_IRQ_PEND, 32'h0000_0000);
      check(cpu_irq_out, 32'h0);
    end
    wr(CSIR_OFS_IRQ_PEND, 32'hFFFF_FFFF);
    rd_chk(CSIR_OFS_IRQ_PEND, 32'h0000_07FF);
    wr(CSIR_OFS_STATUS, 32'h0000_0000);
    check(cpu_irq_out, 32'h0);
    check(dma_irq_out, 32'h7FF);
    wr(CSIR_OFS_IRQ_EN, 32'h0000_0009);
    check(dma_irq_out, 32'h0);
    wr(CSIR_OFS_STATUS, 32'h0000_2000);
    check(cpu_irq_out, 32'h1);
    core.ack();
    repeat (2) @(posedge clk_in);
    rd_chk(CSIR_OFS_IRQ_PEND, 32'h0000_07FE);
    wr(CSIR_OFS_IRQ_EN, 32'h0000_0000);
    check(cpu_irq_out, 32'h0);
    wr(CSIR_OFS_PIN_FLAG, 32'hFFFF_FFFF);
    check({oe_1_n, oe_0_n, drv_1, drv_0}, 32'h3);
    repeat (6) @(posedge clk_in);
    rd_chk(CSIR_OFS_PIN_FLAG, 32'h0000_00EE);
    wr(CSIR_OFS_PIN_FLAG, 32'h0000_0000);
    repeat (6) @(posedge clk_in);
    rd_chk(CSIR_OFS_PIN_FLAG, 32'h0000_0008);
    wr(4'h9, 32'hFFFF_FFFF);
    rd_chk(4'h9, 32'h0000_0000);
    for (int k = 0; k < 4; k++)
    begin
      wr(CSIR_OFS_STATUS, alu_tab[k][0]);
      wr(CSIR_OFS_ALU_CTRL, alu_tab[k][1]);
      wr(CSIR_OFS_ALU_A, alu_tab[k][2]);
      wr(CSIR_OFS_ALU_B, 32'h0000_0001);
      rd_chk(CSIR_OFS_ALU_RES, alu_tab[k][3]);
      rd(CSIR_OFS_STATUS, v);
      check(v & 32'h0000_0022, 32'h0000_0022);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
